//--- hw/omsc_top.sv
/*
 * omsc_top: captures the operating mode from straps at reset release,
 * holds the mode control register with its per-mode write policies,
 * and decodes the bus/port configuration for the rest of the chip.
 * assumes: straps are stable around reset release; register port is
 * a simple one-cycle strobe slave with read data one cycle later.
 */
// Summary of operation
// - straps captured at reset release into mode bits
// - debug pin selects normal/special, straps select mode
// - single-chip: GPIO; wide: both ports bus
// - narrow: port A data, two byte cycles
// - special single-chip starts in active debug
// - peripheral mode holds CPU, reset-only entry/exit
// - mode register unmapped in peripheral mode
// - special bit writable in special, first ignored
// - strap bits write-once normal, first ignored special
// - stretch bit controls bus clock stretching
// - stretch bit reads one in expanded modes
// - stretch bit write-once normal, anytime special
// - visibility shows internal cycles, not single-chip
// - special narrow visibility shows wide data
// - visibility, emulate bits: once normal, special skip-first
// - wait-stop shuts bus after drain delay
// - wait-stop writable normal only, readable unless peripheral
// - port K emulate unmaps port K regs, not single-chip
// - port E emulate unmaps port E regs, not single-chip
module omsc_top
    import omsc_pkg::*;
#(
    parameter int WAIT_DRAIN = OMSC_WAIT_DRAIN_DEF
) (
    input  wire logic              core_clk,
    input  wire logic              rst,
    input  wire logic              debug_strap_pin,
    input  wire logic              strap_hi_bit,
    input  wire logic              strap_lo_bit,
    input  wire logic              wait_mode,
    input  wire logic              ext_bus_busy,
    input  wire omsc_pkg::omsc_req_t reg_req,
    output logic [7:0]             reg_rdata,
    output omsc_pkg::omsc_ctrl_t   mode_ctrl,
    output omsc_pkg::omsc_cfg_t    bus_cfg,
    output logic                   bus_if_stopped
);
    import omsc_pkg::*;

    // drain counter is 8 bits wide and must count at least once
    generate
        if (WAIT_DRAIN < 1 || WAIT_DRAIN > 255) begin : g_drain_chk
            $error("WAIT_DRAIN out of range");
        end
    endgenerate

    // ************************************************************
    // reset-release strap capture
    // ************************************************************
    logic       in_rst_q;
    logic       cap_q;
    omsc_ctrl_t ctrl_q;
    logic       first_wr_seen_q;   // special modes: first write swallowed
    logic       once_done_q;       // normal modes: write-once used
    logic       bdm_q;
    logic [7:0] rdata_q;
    logic [7:0] drain_q;
    logic       stopped_q;

    // captured one clock after release so straps are never loaded by reset
    wire        release_w = in_rst_q && !rst;

    // mode decode, reserved normal code forced to peripheral
    wire        special_w = !ctrl_q.special_mode_not;
    wire        periph_w  = ctrl_q.strap == OMSC_ST_PERIPH;
    wire        single_w  = ctrl_q.strap == OMSC_ST_SINGLE;
    wire        narrow_w  = ctrl_q.strap == OMSC_ST_NARROW;
    wire        wide_w    = ctrl_q.strap == OMSC_ST_WIDE;
    wire        expand_w  = narrow_w || wide_w;

    omsc_mode_t mode_w;
    assign mode_w = periph_w ? OMSC_M_SPERIPH :
                    special_w ? (single_w ? OMSC_M_SSINGLE : narrow_w ? OMSC_M_SNARROW : OMSC_M_SWIDE) :
                    (single_w ? OMSC_M_NSINGLE : narrow_w ? OMSC_M_NNARROW : OMSC_M_NWIDE);

    // strap decode at capture time
    wire        cap_special_w = !debug_strap_pin;
    wire [1:0]  cap_strap_w   = {strap_hi_bit, strap_lo_bit};

    // ************************************************************
    // register access decode
    // ************************************************************
    // register absent from map in peripheral mode
    wire        hit_w  = (reg_req.addr == OMSC_MODE_OFF) && !periph_w && cap_q;
    wire        wr_w   = reg_req.wr && hit_w;
    wire [7:0]  wd_w   = reg_req.wdata;
    // special writes only count after the first; normal only before once
    wire        sp_ok_w = special_w && first_wr_seen_q;
    wire        nm_ok_w = !special_w && !once_done_q;

    // special bit: only while special, first write ignored
    wire        special_mode_not_d = (wr_w && sp_ok_w) ? wd_w[OMSC_B_SPECIAL_MODE_NOT] : ctrl_q.special_mode_not;

    // strap bits never move to peripheral or reserved code
    wire [1:0]  strap_req_w = wd_w[OMSC_B_STRHI:OMSC_B_STRLO];
    wire        strap_ok_w  = wr_w && (sp_ok_w || nm_ok_w) && (strap_req_w != OMSC_ST_PERIPH);
    wire [1:0]  strap_d     = strap_ok_w ? strap_req_w : ctrl_q.strap;

    // stretch bit: once in normal, anytime in special
    wire        bus_clock_stretch_en_d = (wr_w && (special_w || nm_ok_w)) ? wd_w[OMSC_B_BUS_CLOCK_STRETCH_EN] : ctrl_q.bus_clock_stretch_en;

    // visibility and emulation bits share the skip-first policy
    wire        opt_wr_w = wr_w && (sp_ok_w || nm_ok_w);
    wire        internal_visibility_d   = opt_wr_w ? wd_w[OMSC_B_INTERNAL_VISIBILITY] : ctrl_q.internal_visibility;
    wire        emk_d    = opt_wr_w ? wd_w[OMSC_B_EMK] : ctrl_q.port_k_emulate;
    wire        eme_d    = opt_wr_w ? wd_w[OMSC_B_EME] : ctrl_q.port_e_emulate;

    // wait-stop writable in normal modes at any time only
    wire        wstop_d = (wr_w && !special_w) ? wd_w[OMSC_B_WSTOP] : ctrl_q.bus_if_wait_stop;

    // stretch reads as one whenever an expanded mode is active
    wire        bus_clock_stretch_en_rd_w = ctrl_q.bus_clock_stretch_en || expand_w;
    wire [7:0]  reg_view_w = {ctrl_q.special_mode_not, ctrl_q.strap, bus_clock_stretch_en_rd_w,
                              ctrl_q.internal_visibility, ctrl_q.bus_if_wait_stop,
                              ctrl_q.port_k_emulate, ctrl_q.port_e_emulate};
    wire [7:0]  rdata_d = (reg_req.rd && hit_w) ? reg_view_w : OMSC_RD_ZERO;

    // ************************************************************
    // control register
    // ************************************************************
    // reset loads constants only; straps are caught on the release edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            in_rst_q        <= 1'b1;
            cap_q           <= 1'b0;
            ctrl_q          <= '0;
            first_wr_seen_q <= 1'b0;
            once_done_q     <= 1'b0;
            bdm_q           <= 1'b0;
        end else if (release_w) begin
            in_rst_q <= 1'b0;
            cap_q    <= 1'b1;
            ctrl_q.special_mode_not     <= !cap_special_w;
            ctrl_q.strap                <= (cap_strap_w == OMSC_ST_PERIPH) ? OMSC_ST_PERIPH : cap_strap_w;
            ctrl_q.bus_clock_stretch_en <= 1'b1;
            ctrl_q.internal_visibility  <= cap_special_w;
            ctrl_q.bus_if_wait_stop     <= 1'b0;
            ctrl_q.port_k_emulate       <= cap_special_w;
            ctrl_q.port_e_emulate       <= cap_special_w;
            // special single-chip enters debug at once
            bdm_q <= cap_special_w && (cap_strap_w == OMSC_ST_SINGLE);
        end else begin
            // peripheral mode fixed: mode bits never written here
            ctrl_q.special_mode_not     <= special_mode_not_d;
            ctrl_q.strap                <= strap_d;
            ctrl_q.bus_clock_stretch_en <= bus_clock_stretch_en_d;
            ctrl_q.internal_visibility  <= internal_visibility_d;
            ctrl_q.bus_if_wait_stop     <= wstop_d;
            ctrl_q.port_k_emulate       <= emk_d;
            ctrl_q.port_e_emulate       <= eme_d;
            if (wr_w) begin
                first_wr_seen_q <= 1'b1;
                once_done_q     <= once_done_q || !special_w;
            end
        end
    end

    // ************************************************************
    // read data and wait-mode shutdown
    // ************************************************************
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= OMSC_RD_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // drain counter lets the last bus cycle finish before stop
    wire       stop_req_w = ctrl_q.bus_if_wait_stop && wait_mode;
    wire [7:0] drain_max_w = 8'(WAIT_DRAIN);
    always_ff @(posedge core_clk) begin
        if (rst || !stop_req_w) begin
            drain_q   <= 8'h00;
            stopped_q <= 1'b0;
        end else if (ext_bus_busy) begin
            drain_q <= 8'h00;   // restart while traffic remains
        end else if (drain_q != drain_max_w) begin
            drain_q <= drain_q + 8'h01;
        end else begin
            stopped_q <= 1'b1;
        end
    end

    // ************************************************************
    // configuration outputs
    // ************************************************************
    // single-chip has no bus; wide carries data on both ports
    assign bus_cfg.ext_bus_en   = !single_w;
    assign bus_cfg.port_b_data  = wide_w || periph_w;
    // narrow modes split 16-bit transfers, high byte first
    assign bus_cfg.narrow_split = narrow_w;
    // visibility passed on to the bus only outside single-chip modes
    assign bus_cfg.vis_en       = ctrl_q.internal_visibility && !single_w;
    // special narrow with visibility shows wide data
    assign bus_cfg.vis_wide     = ctrl_q.internal_visibility && special_w && narrow_w;
    assign bus_cfg.cpu_hold     = periph_w;
    // debug is not activated in peripheral mode
    assign bus_cfg.bdm_active   = bdm_q && !periph_w;
    // port K unmapped when emulated outside single-chip
    assign bus_cfg.port_k_mapped = single_w || !ctrl_q.port_k_emulate;
    // port E unmapped when emulated outside single-chip
    assign bus_cfg.port_e_mapped = !(expand_w || periph_w) || !ctrl_q.port_e_emulate;
    assign bus_cfg.mode_reg_mapped = !periph_w;

    assign mode_ctrl      = '{special_mode_not: ctrl_q.special_mode_not, strap: ctrl_q.strap,
                              bus_clock_stretch_en: bus_clock_stretch_en_rd_w,
                              internal_visibility: ctrl_q.internal_visibility,
                              bus_if_wait_stop: ctrl_q.bus_if_wait_stop,
                              port_k_emulate: ctrl_q.port_k_emulate,
                              port_e_emulate: ctrl_q.port_e_emulate};
    assign reg_rdata      = rdata_q;
    assign bus_if_stopped = stopped_q;

    // keep the mode enum visible for debug probes
    omsc_mode_t mode_q;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_q <= OMSC_M_NSINGLE;
        end else begin
            mode_q <= mode_w;
        end
    end

endmodule

//--- hw/omsc_pkg.sv
/*
 * omsc_pkg: constants and types for the operating mode select and
 * mode control register block.
 * assumes: one 8-bit register reached over a plain strobe port.
 */
package omsc_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] OMSC_MODE_OFF = 8'h00;  // operating_mode_control
    localparam logic [7:0] OMSC_RD_ZERO  = 8'h00;  // answer to unmapped reads

    // field positions
    localparam int OMSC_B_SPECIAL_MODE_NOT = 7;
    localparam int OMSC_B_STRHI = 6;
    localparam int OMSC_B_STRLO = 5;
    localparam int OMSC_B_BUS_CLOCK_STRETCH_EN  = 4;
    localparam int OMSC_B_INTERNAL_VISIBILITY  = 3;
    localparam int OMSC_B_WSTOP = 2;
    localparam int OMSC_B_EMK   = 1;
    localparam int OMSC_B_EME   = 0;

    // strap codes
    localparam logic [1:0] OMSC_ST_SINGLE = 2'h0;
    localparam logic [1:0] OMSC_ST_NARROW = 2'h1;
    localparam logic [1:0] OMSC_ST_PERIPH = 2'h2;
    localparam logic [1:0] OMSC_ST_WIDE   = 2'h3;

    // wait-stop drain delay (cycles), default for the top parameter
    localparam int OMSC_WAIT_DRAIN_DEF = 4;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [2:0] {
        OMSC_M_NSINGLE, OMSC_M_NNARROW, OMSC_M_NWIDE,
        OMSC_M_SSINGLE, OMSC_M_SNARROW, OMSC_M_SWIDE, OMSC_M_SPERIPH
    } omsc_mode_t;

    typedef struct packed {
        logic       special_mode_not;
        logic [1:0] strap;
        logic       bus_clock_stretch_en;
        logic       internal_visibility;
        logic       bus_if_wait_stop;
        logic       port_k_emulate;
        logic       port_e_emulate;
    } omsc_ctrl_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } omsc_req_t;

    typedef struct packed {
        logic ext_bus_en;      // multiplexed bus present
        logic port_b_data;     // second port carries data
        logic narrow_split;    // 16-bit transfers as two byte cycles
        logic vis_en;          // internal cycles shown externally
        logic vis_wide;        // visible data across both ports
        logic cpu_hold;        // processor inactive
        logic bdm_active;      // debug active out of reset
        logic port_k_mapped;
        logic port_e_mapped;
        logic mode_reg_mapped;
    } omsc_cfg_t;

endpackage

//--- tb/omsc_top_props.sv
/* omsc_top_props: port checker for the mode select block.
 * assumes: bound into omsc_top, one clock, synchronous active-high reset. */
module omsc_top_props
    import omsc_pkg::*;
#(
    parameter int WAIT_DRAIN = OMSC_WAIT_DRAIN_DEF
) (
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic                 debug_strap_pin,
    input wire logic                 strap_hi_bit,
    input wire logic                 strap_lo_bit,
    input wire logic                 wait_mode,
    input wire logic                 ext_bus_busy,
    input wire omsc_pkg::omsc_req_t  reg_req,
    input wire logic [7:0]           reg_rdata,
    input wire omsc_pkg::omsc_ctrl_t mode_ctrl,
    input wire omsc_pkg::omsc_cfg_t  bus_cfg,
    input wire logic                 bus_if_stopped
);
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************
    // helpers
    // ****************************************
    logic [1:0] up_q;
    logic       live;
    logic       expd;
    logic       ssc;
    // straps are only trusted two edges after release, capture needs one
    assign live = up_q[1];
    assign expd = mode_ctrl.strap[0];
    assign ssc  = !debug_strap_pin && !strap_hi_bit && !strap_lo_bit;
    always_ff @(posedge core_clk) up_q <= rst ? 2'h0 : {up_q[0], 1'b1};
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // ****************************************
    // properties
    // ****************************************
    a_strap_capture: assert property (
        $fell(rst) && !(debug_strap_pin && strap_hi_bit && !strap_lo_bit) |=>
        {mode_ctrl.special_mode_not, mode_ctrl.strap} == $past({debug_strap_pin, strap_hi_bit, strap_lo_bit}))
        else $error("strap capture wrong");
    a_reset_special: assert property (
        $fell(rst) && !debug_strap_pin |=> mode_ctrl[4:0] == 5'h1B) else $error("special reset bits");
    a_reset_normal: assert property (
        $fell(rst) && debug_strap_pin && !(strap_hi_bit && !strap_lo_bit) |=> mode_ctrl[4:0] == 5'h10)
        else $error("normal reset bits");
    a_debug_start: assert property (
        $fell(rst) |=> bus_cfg.bdm_active == $past(ssc)) else $error("debug start wrong");
    a_stretch_exp: assert property (
        live && expd |-> mode_ctrl.bus_clock_stretch_en) else $error("stretch not one");
    a_vis_single: assert property (
        mode_ctrl.strap == OMSC_ST_SINGLE |-> !bus_cfg.vis_en) else $error("visibility in single chip");
    a_port_map: assert property (
        live && mode_ctrl.strap == OMSC_ST_SINGLE |-> bus_cfg.port_k_mapped && bus_cfg.port_e_mapped)
        else $error("port regs unmapped");
    a_emul_unmap: assert property (
        live && expd |-> bus_cfg.port_e_mapped == !mode_ctrl.port_e_emulate &&
        bus_cfg.port_k_mapped == !mode_ctrl.port_k_emulate) else $error("emulate map wrong");
    a_periph_hold: assert property (
        live && mode_ctrl.strap == OMSC_ST_PERIPH |-> !bus_cfg.mode_reg_mapped && bus_cfg.cpu_hold)
        else $error("peripheral mode map");
    a_rd_idle: assert property (
        !$past(reg_req.rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
    a_rd_value: assert property (
        live && reg_req.rd && reg_req.addr == OMSC_MODE_OFF && bus_cfg.mode_reg_mapped |=>
        reg_rdata == $past(mode_ctrl)) else $error("read value wrong");
    a_wstop_lock: assert property (
        live && !mode_ctrl.special_mode_not |=> $stable(mode_ctrl.bus_if_wait_stop)) else $error("wait stop written");
    a_drain_delay: assert property (
        $rose(wait_mode) |=> !bus_if_stopped) else $error("stopped without delay");
    a_stop_idle: assert property (
        (wait_mode && mode_ctrl.bus_if_wait_stop && !ext_bus_busy) [*8] |-> bus_if_stopped)
        else $error("bus never stopped");
    a_stop_cause: assert property (
        bus_if_stopped |-> $past(wait_mode) && $past(mode_ctrl.bus_if_wait_stop)) else $error("stopped w/o cause");
endmodule

bind omsc_top omsc_top_props #(.WAIT_DRAIN(WAIT_DRAIN)) u_props (
    .core_clk(core_clk), .rst(rst), .debug_strap_pin(debug_strap_pin), .strap_hi_bit(strap_hi_bit),
    .strap_lo_bit(strap_lo_bit), .wait_mode(wait_mode), .ext_bus_busy(ext_bus_busy), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .mode_ctrl(mode_ctrl), .bus_cfg(bus_cfg), .bus_if_stopped(bus_if_stopped));

//--- tb/omsc_bus_partner.sv
/* omsc_bus_partner: external memory on the multiplexed bus, seen only as activity.
 * assumes: bench clock and reset; the mode block reads busy as a level. */
module omsc_bus_partner (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic slow,
    output logic      ext_bus_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned left_q;  // cycles left in this burst
    // no debug traffic
    // slow bursts hold the bus so the drain must restart
    always_ff @(posedge core_clk) begin
        if (rst) left_q <= 0;
        else if (left_q != 0) left_q <= left_q - 1;
        else if ($urandom_range(3) == 0) left_q <= slow ? 6 : 1;
    end
    assign ext_bus_busy = left_q != 0;
endmodule

//--- tb/omsc_top_tb.sv
/* omsc_top_tb: walks all strap modes, random register traffic, wait shutdown.
 * assumes: omsc_top with its bound checker and the bus partner model. */
module omsc_top_tb
    import omsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       core_clk = 1'b0, rst = 1'b1, wait_mode = 1'b0, slow = 1'b0;
    logic       debug_strap_pin = 1'b1, strap_hi_bit = 1'b0, strap_lo_bit = 1'b0;
    logic       ext_bus_busy, bus_if_stopped;
    logic [7:0] reg_rdata;
    omsc_req_t  reg_req = '0;
    omsc_ctrl_t mode_ctrl;
    omsc_cfg_t  bus_cfg;
    int         err_total = 0, checked = 0, wcnt;
    logic [7:0] m;  // model of the stored register
    bit         periph, once;  // once: normal-mode write-once spent
    always #10 core_clk = ~core_clk;
    omsc_top #(.WAIT_DRAIN(4)) dut (.core_clk(core_clk), .rst(rst), .debug_strap_pin(debug_strap_pin),
        .strap_hi_bit(strap_hi_bit), .strap_lo_bit(strap_lo_bit), .wait_mode(wait_mode),
        .ext_bus_busy(ext_bus_busy), .reg_req(reg_req), .reg_rdata(reg_rdata), .mode_ctrl(mode_ctrl),
        .bus_cfg(bus_cfg), .bus_if_stopped(bus_if_stopped));
    omsc_bus_partner u_mem (.core_clk(core_clk), .rst(rst), .slow(slow), .ext_bus_busy(ext_bus_busy));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // register view: bus modes always read stretch as one, peripheral reads nothing
    function automatic logic [7:0] view();
        logic [7:0] v;
        v = m;
        if (m[5]) v[4] = 1'b1;
        return periph ? OMSC_RD_ZERO : v;
    endfunction
    task automatic do_reset(input logic [2:0] s);
        @(posedge core_clk);
        rst <= 1'b1;
        {debug_strap_pin, strap_hi_bit, strap_lo_bit} <= s;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        periph = s[1:0] == 2'h2;
        m = {s, (s[2] ? 5'h10 : 5'h1B)};
        wcnt = 0;
        once = 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        reg_req <= '0;
        // write policy: special skips the first write except stretch, normal locks after it except wait-stop
        if (a == OMSC_MODE_OFF && !periph) begin
            if (!m[7]) begin
                m[4] = d[4];
                if (wcnt > 0) begin
                    m[7] = d[7];
                    m[3] = d[3];
                    m[1:0] = d[1:0];
                    if (d[6:5] != OMSC_ST_PERIPH) m[6:5] = d[6:5];
                end
            end else begin
                m[2] = d[2];
                if (!once) begin
                    m[4:3] = d[4:3];
                    m[1:0] = d[1:0];
                    if (d[6:5] != OMSC_ST_PERIPH) m[6:5] = d[6:5];
                end
                once = 1'b1;
            end
            wcnt++;
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        reg_req <= '0;
        #1 v = reg_rdata;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        #(20 * 20000);
        err_total++;
        close_out();
    end
    initial begin
        logic [7:0] v, a, d;
        void'($urandom(32'h5931));
        for (int s = 0; s < 8; s++) begin
            do_reset(s[2:0]);
            slow <= s[0];
            rd(OMSC_MODE_OFF, v);
            chk(v, view());
            chk(8'(bus_cfg.bdm_active), 8'(s == 0));
            chk(8'(bus_cfg.cpu_hold), 8'(periph));
            repeat (6) begin
                a = ($urandom_range(3) == 0) ? 8'($urandom) : OMSC_MODE_OFF;
                d = 8'($urandom);
                wr(a, d);
                rd(a, v);
                chk(v, (a == OMSC_MODE_OFF) ? view() : OMSC_RD_ZERO);
                chk(8'(bus_cfg.ext_bus_en), 8'(m[6:5] != 2'h0));
                chk(8'(bus_cfg.narrow_split), 8'(m[6:5] == 2'h1));
                chk(8'(bus_cfg.vis_wide), 8'(m[3] && !m[7] && m[6:5] == 2'h1));
            end
            // wait shutdown only when the stop bit is set, and never at once
            @(posedge core_clk);
            wait_mode <= 1'b1;
            @(posedge core_clk);
            #1 chk(8'(bus_if_stopped), 8'h00);
            for (int i = 0; i < 1000 && bus_if_stopped !== 1'b1; i++) begin
                @(posedge core_clk);
                #1;
            end
            chk(8'(bus_if_stopped), 8'(m[2]));
            @(posedge core_clk);
            wait_mode <= 1'b0;
            repeat (3) @(posedge core_clk);
            #1 chk(8'(bus_if_stopped), 8'h00);
            $display("mode test %0d done", s);
        end
        close_out();
    end
endmodule
